// *** logic/pmic_fault_irq_reset_supervisor.sv ***
// fault supervisor: flags, masks, latched faults, open-drain interrupt,
// system reset, holdoff and restart timing, external supply enable.
// assumes a serial interface engine that presents byte reads and writes
// and analog comparators that arrive asynchronously to mclk_i.
`timescale 1ns/100ps
`include "fault_sup_map.svh"
`default_nettype none
module pmic_fault_irq_reset_supervisor #(
   parameter int MS_CYCLES = `MS_NS / `CLK_NS,
   parameter int LDO_CYCLES = `LDO_ILIM_NS / `CLK_NS,
   parameter logic [15:0] IMAGE = `IMG_RST
) (
   // clock and reset
   input wire logic mclk_i,
   input wire logic rstn_i,
   // register access from the serial interface engine
   input wire logic reg_rd_i,
   input wire logic reg_wr_i,
   input wire logic [7:0] reg_addr_i,
   input wire logic [7:0] reg_wdata_i,
   output logic [7:0] reg_rdata_o,
   // buck comparators
   input wire logic [2:0] buck_ov_i,
   input wire logic [2:0] buck_uv_i,
   input wire logic [2:0] buck_oc75_i,
   input wire logic [2:0] buck_oc122_i,
   input wire logic [2:0] buck_sw_clk_i,
   // ldo comparators
   input wire logic [1:0] ldo_ov_i,
   input wire logic [1:0] ldo_uv_i,
   input wire logic [1:0] ldo_ilim_i,
   input wire logic [1:0] ldo_ss_done_i,
   // die temperature and input path
   input wire logic temp_warn_i,
   input wire logic temp_shdn_i,
   input wire logic in_ov_i,
   input wire logic in_uv_i,
   input wire logic in_ocw_i,
   // power good of rails and of the external supply
   input wire logic [4:0] rail_pg_i,
   input wire logic external_power_good_i,
   // power path controls
   output logic [4:0] rail_en_o,
   output logic inrush_gate_drive_o,
   output logic external_supply_enable_o,
   output logic sys_reset_n_o,
   // open-drain interrupt pin
   input wire logic fault_irq_n_i,
   output logic fault_irq_n_o,
   output logic fault_irq_n_oe_n_o
);
   // ***************************************************************
   // parameters checks and shared constants
   // ***************************************************************
   localparam int NSYNC = 34;
   localparam int TW = $clog2(MS_CYCLES);
   localparam int LW = $clog2(LDO_CYCLES + 2);
   localparam logic [7:0][7:0] ST_OFF = `ST_OFFS;
   localparam logic [4:0] MON = IMAGE[`IMG_MON_LSB +: 5];
   localparam logic [4:0] TRIG = IMAGE[`IMG_TRIG_LSB +: 5];
   localparam logic [2:0] ON_DLY = IMAGE[`IMG_ON_LSB +: 3];
   localparam logic [2:0] OFF_DLY = IMAGE[`IMG_OFF_LSB +: 3];

   if (MS_CYCLES < 2 || LDO_CYCLES < 2) begin : g_bad
      $error("tick and ldo counts must be at least two");
   end

   // ***************************************************************
   // input synchronisers
   // ***************************************************************
   logic [NSYNC-1:0] raw;
   logic [NSYNC-1:0] s1;
   logic [NSYNC-1:0] s2;
   logic [NSYNC-1:0] s3;
   logic [NSYNC-1:0] syn;
   logic external_power_good;
   logic [4:0] rail_pg;
   logic in_ocw;
   logic in_uv;
   logic in_ov;
   logic t_shdn;
   logic t_warn;
   logic [1:0] ldo_ssd;
   logic [1:0] ldo_ilim;
   logic [1:0] ldo_uv;
   logic [1:0] ldo_ov;
   logic [2:0] sw_clk;
   logic [2:0] oc122;
   logic [2:0] oc75;
   logic [2:0] buck_uv;
   logic [2:0] buck_ov;

   assign raw = {external_power_good_i, rail_pg_i, in_ocw_i, in_uv_i,
      in_ov_i, temp_shdn_i, temp_warn_i, ldo_ss_done_i, ldo_ilim_i,
      ldo_uv_i, ldo_ov_i, buck_sw_clk_i, buck_oc122_i, buck_oc75_i,
      buck_uv_i, buck_ov_i};
   assign {external_power_good, rail_pg, in_ocw, in_uv, in_ov, t_shdn, t_warn,
      ldo_ssd, ldo_ilim, ldo_uv, ldo_ov, sw_clk, oc122, oc75, buck_uv,
      buck_ov} = syn;

   // a level counts only once the second and third stage agree
   always_ff @(posedge mclk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         s1 <= '0;
         s2 <= '0;
         s3 <= '0;
         syn <= '0;
      end else begin
         s1 <= raw;
         s2 <= s1;
         s3 <= s2;
         syn <= (s2 & s3) | (syn & (s2 | s3));
      end
   end

   // ***************************************************************
   // millisecond tick
   // ***************************************************************
   logic [TW-1:0] tick_cnt;
   logic tick;

   assign tick = (tick_cnt == TW'(MS_CYCLES - 1));

   // one shared tick keeps every delay counter narrow
   always_ff @(posedge mclk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         tick_cnt <= '0;
      end else if (tick) begin
         tick_cnt <= '0;
      end else begin
         tick_cnt <= tick_cnt + 1'b1;
      end
   end

   // ***************************************************************
   // buck overcurrent levels
   // ***************************************************************
   logic [2:0] sw_d;
   logic [2:0] sw_rise;
   logic [2:0] oc1_flag;
   logic [2:0] rs_busy;

   assign sw_rise = sw_clk & ~sw_d;

   // switch edges, taken after the filter
   always_ff @(posedge mclk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         sw_d <= '0;
      end else begin
         sw_d <= sw_clk;
      end
   end

   for (genvar i = 0; i < 3; i++) begin : g_buck
      logic [4:0] oc_cnt;
      logic [3:0] rs_cnt;

      assign oc1_flag[i] = (oc_cnt > `BUCK_OC_CYC);

      // run of switch cycles at the first level, saturating
      always_ff @(posedge mclk_i or negedge rstn_i) begin
         if (!rstn_i) begin
            oc_cnt <= '0;
         end else if (!oc75[i]) begin
            oc_cnt <= '0;
         end else if (sw_rise[i] && oc_cnt <= `BUCK_OC_CYC) begin
            oc_cnt <= oc_cnt + 1'b1;
         end
      end

      // third level: this buck alone off, no mask can stop it
      always_ff @(posedge mclk_i or negedge rstn_i) begin
         if (!rstn_i) begin
            rs_busy[i] <= 1'b0;
            rs_cnt <= '0;
         end else if (oc122[i]) begin
            rs_busy[i] <= 1'b1;
            rs_cnt <= '0;
         end else if (rs_busy[i] && tick) begin
            if (rs_cnt == `RESTART_MS - 4'h1) begin
               rs_busy[i] <= 1'b0;
            end
            rs_cnt <= rs_cnt + 1'b1;
         end
      end
   end

   // ***************************************************************
   // ldo current limit filter
   // ***************************************************************
   logic [1:0] ldo_flag;

   for (genvar j = 0; j < 2; j++) begin : g_ldo
      logic [LW-1:0] il_cnt;

      assign ldo_flag[j] = (il_cnt > LW'(LDO_CYCLES));

      // counted only once soft start is over
      always_ff @(posedge mclk_i or negedge rstn_i) begin
         if (!rstn_i) begin
            il_cnt <= '0;
         end else if (!(ldo_ilim[j] && ldo_ssd[j])) begin
            il_cnt <= '0;
         end else if (il_cnt <= LW'(LDO_CYCLES)) begin
            il_cnt <= il_cnt + 1'b1;
         end
      end
   end

   // ***************************************************************
   // flags, masks, latched faults
   // ***************************************************************
   logic [7:0][7:0] live;
   logic [7:0][7:0] mask;
   logic [7:0][7:0] lat;
   logic [7:0] rd_hit;
   logic [1:0] rdly;
   logic uvov_trip;
   logic therm_trip;

   // flags follow the filtered sources whatever the masks say
   assign live[0] = {2'h0, buck_uv, buck_ov};
   assign live[1] = {4'h0, ldo_uv, ldo_ov};
   assign live[2] = {5'h00, oc1_flag};
   assign live[3] = {6'h00, ldo_flag};
   assign live[4] = {6'h00, t_shdn, t_warn};
   assign live[5] = {6'h00, in_uv, in_ov};
   assign live[6] = {7'h00, in_ocw};
   assign live[7] = {5'h00, oc122};

   for (genvar g = 0; g < 8; g++) begin : g_hit
      assign rd_hit[g] = reg_rd_i && (reg_addr_i == ST_OFF[g]);
   end

   assign uvov_trip = |({live[1][3:0], live[0][5:0]} &
      ~{mask[1][3:0], mask[0][5:0]});
   assign therm_trip = t_shdn && !mask[4][`TSHDN_BIT];

   // set wins over a clearing read; a live bit survives its read
   always_ff @(posedge mclk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         lat <= '0;
      end else begin
         for (int g = 0; g < 8; g++) begin
            lat[g] <= (live[g] & ~mask[g]) |
               (lat[g] & ~({8{rd_hit[g]}} & ~live[g]));
         end
      end
   end

   // masks default to blocking every source
   always_ff @(posedge mclk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         mask <= {8{`MASK_RST}};
      end else if (reg_wr_i) begin
         for (int g = 0; g < 8; g++) begin
            if (reg_addr_i == 8'(`MASK_BASE + g)) begin
               mask[g] <= reg_wdata_i;
            end
         end
      end
   end

   // reset release delay select
   always_ff @(posedge mclk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         rdly <= `RDLY_RST;
      end else if (reg_wr_i && reg_addr_i == `RDLY_ADDR) begin
         rdly <= reg_wdata_i[1:0];
      end
   end

   // ***************************************************************
   // register read port
   // ***************************************************************
   logic [7:0] next_rdata;

   // status reads return the bits before the clear lands
   always_comb begin
      next_rdata = 8'h00;
      for (int g = 0; g < 8; g++) begin
         if (reg_addr_i == ST_OFF[g]) begin
            next_rdata = lat[g];
         end else if (reg_addr_i == 8'(`FLAG_BASE + g)) begin
            next_rdata = live[g];
         end else if (reg_addr_i == 8'(`MASK_BASE + g)) begin
            next_rdata = mask[g];
         end
      end
      if (reg_addr_i == `RDLY_ADDR) begin
         next_rdata = {6'h00, rdly};
      end
   end

   always_ff @(posedge mclk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         reg_rdata_o <= 8'h00;
      end else if (reg_rd_i) begin
         reg_rdata_o <= next_rdata;
      end
   end

   // ***************************************************************
   // sequencer and holdoff
   // ***************************************************************
   fault_sup_pkg::seq_state_t state;
   logic [6:0] hold_cnt;
   logic in_bad;
   logic [4:0] rail_hold;

   assign in_bad = in_ov || in_uv;
   // only the bucks have a third current level; ldos never sit out alone
   assign rail_hold = {2'h0, rs_busy};

   always_ff @(posedge mclk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         state <= fault_sup_pkg::SEQ_OFF;
         hold_cnt <= '0;
      end else begin
         case (state)
            fault_sup_pkg::SEQ_OFF: begin
               if (!in_bad) begin
                  state <= fault_sup_pkg::SEQ_RUN;
               end
            end
            fault_sup_pkg::SEQ_RUN: begin
               if (in_bad) begin
                  state <= fault_sup_pkg::SEQ_OFF;
               end else if (uvov_trip || therm_trip) begin
                  state <= fault_sup_pkg::SEQ_HOLD;
                  hold_cnt <= '0;
               end
            end
            fault_sup_pkg::SEQ_HOLD: begin
               if (in_bad) begin
                  state <= fault_sup_pkg::SEQ_OFF;
               end else if (tick) begin
                  if (hold_cnt == `HOLDOFF_MS - 7'h1) begin
                     state <= fault_sup_pkg::SEQ_RUN;
                  end
                  hold_cnt <= hold_cnt + 7'h1;
               end
            end
            default: state <= fault_sup_pkg::SEQ_OFF;
         endcase
      end
   end

   // rails start on their trigger; a tripped buck sits out alone
   always_ff @(posedge mclk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         rail_en_o <= '0;
      end else begin
         for (int k = 0; k < 5; k++) begin
            rail_en_o[k] <= (state == fault_sup_pkg::SEQ_RUN) &&
               (!TRIG[k] || external_power_good) &&
               !rail_hold[k];
         end
      end
   end

   // overvoltage at the sense input kills the gate at once
   always_ff @(posedge mclk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         inrush_gate_drive_o <= 1'b0;
      end else begin
         inrush_gate_drive_o <= (state != fault_sup_pkg::SEQ_OFF) &&
            !in_ov && !in_uv;
      end
   end

   // ***************************************************************
   // external supply enable
   // ***************************************************************
   logic ext_trig;
   logic [2:0] ext_cnt;

   assign ext_trig = (state == fault_sup_pkg::SEQ_RUN);

   // a trigger that flips back mid delay restarts the count
   always_ff @(posedge mclk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         external_supply_enable_o <= 1'b0;
         ext_cnt <= '0;
      end else if (ext_trig == external_supply_enable_o) begin
         ext_cnt <= '0;
      end else if (tick) begin
         if (ext_cnt == (ext_trig ? ON_DLY : OFF_DLY)) begin
            external_supply_enable_o <= ext_trig;
            ext_cnt <= '0;
         end else begin
            ext_cnt <= ext_cnt + 3'h1;
         end
      end
   end

   // ***************************************************************
   // system reset
   // ***************************************************************
   logic rst_bad;
   logic [6:0] rst_cnt;
   logic [6:0] dly_ms;

   assign rst_bad = in_bad || |(MON & ~rail_pg) || uvov_trip;

   always_comb begin
      case (rdly)
         2'h0: dly_ms = `RDLY_MS_0;
         2'h1: dly_ms = `RDLY_MS_1;
         2'h2: dly_ms = `RDLY_MS_2;
         default: dly_ms = `RDLY_MS_3;
      endcase
   end

   // drop at once, release only after a full quiet delay
   always_ff @(posedge mclk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         sys_reset_n_o <= 1'b0;
         rst_cnt <= '0;
      end else if (rst_bad || state != fault_sup_pkg::SEQ_RUN) begin
         sys_reset_n_o <= 1'b0;
         rst_cnt <= '0;
      end else if (!sys_reset_n_o && tick) begin
         if (rst_cnt == dly_ms - 7'h1) begin
            sys_reset_n_o <= 1'b1;
         end
         rst_cnt <= rst_cnt + 7'h1;
      end
   end

   // ***************************************************************
   // open-drain interrupt
   // ***************************************************************
   // the pad only ever pulls low; the pin level itself is not needed
   assign fault_irq_n_o = 1'b0;

   always_ff @(posedge mclk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         fault_irq_n_oe_n_o <= 1'b1;
      end else begin
         fault_irq_n_oe_n_o <= ~(|lat);
      end
   end

   // ***************************************************************
   // checks
   // ***************************************************************
   default clocking cb @(posedge mclk_i);
   endclocking
   default disable iff (!rstn_i);

   sequence fault_seen_s;
      live[0][0] && !mask[0][0];
   endsequence
   sequence irq_low_s;
      lat[0][0] ##1 !fault_irq_n_oe_n_o;
   endsequence

   flag_read_a: assert property (
      reg_rd_i && (reg_addr_i & 8'hf8) == `FLAG_BASE |=>
         reg_rdata_o == $past(live[reg_addr_i[2:0]]))
      else $error("flag read differs from live state");
   latch_set_a: assert property (fault_seen_s |=> irq_low_s)
      else $error("unmasked fault did not assert interrupt");
   irq_release_a: assert property (
      $rose(fault_irq_n_oe_n_o) |-> $past(lat) == '0)
      else $error("interrupt released with latched fault");
   read_hold_a: assert property (
      rd_hit[0] && live[0][0] && lat[0][0] |=>
         lat[0][0] ##1 !fault_irq_n_oe_n_o)
      else $error("read cleared an active fault");
   buck_run_a: assert property (
      $rose(oc1_flag[2]) |-> $past(g_buck[2].oc_cnt) == 5'h10)
      else $error("buck warning after wrong cycle count");
   ldo_time_a: assert property (
      $rose(ldo_flag[1]) |-> $past(ldo_ssd[1]) &&
         $past(g_ldo[1].il_cnt) == LW'(LDO_CYCLES))
      else $error("ldo limit flagged at wrong time");
   reset_fast_a: assert property (in_bad |=> !sys_reset_n_o)
      else $error("reset not asserted on bad input");
   reset_delay_a: assert property (
      $rose(sys_reset_n_o) |-> $past(rst_cnt) == $past(dly_ms) - 7'h1)
      else $error("reset released before its delay");
   holdoff_a: assert property (
      state == fault_sup_pkg::SEQ_RUN && uvov_trip && !in_bad |=>
         state == fault_sup_pkg::SEQ_HOLD ##1 rail_en_o == '0)
      else $error("uv or ov did not enter holdoff");
   buck_trip_a: assert property (
      $rose(oc122[0]) |-> ##2 !rail_en_o[0])
      else $error("buck not disabled at third level");
   gate_off_a: assert property (in_ov |=> !inrush_gate_drive_o)
      else $error("inrush gate on during overvoltage");
endmodule
`default_nettype wire

// *** logic/fault_sup_map.svh ***
// offsets, field positions, reset values and timing figures of the
// fault supervisor; assumes a 200 MHz mclk_i and byte-wide registers
// Summary of operation
// - each fault source has a flag showing its live condition, mask or not
// - an unmasked fault sets its latched bit and pulls the interrupt low
// - interrupt releases only after condition gone and latched bit read
// - reading status while condition persists keeps bit set, interrupt low
// - buck current at 75 percent for over 16 switch cycles flags
// - LDO in current limit over 16 us after soft start flags
// - input over or under voltage is an interrupt source too
// - system reset drops at once on bad input or monitored rail
// - system reset releases after 20 to 100 ms selectable delay
// - unmasked output UV or OV turns all rails off 100 ms, then restarts
// - unmasked output UV or OV also forces system reset low
// - buck at 122 percent disables that buck, restarts after 14 ms
// - masks gate the interrupt and the output UV/OV and shutdown actions; input and 122 percent actions always act
// - die temperature warning raises interrupt unless masked
// - die shutdown temperature turns off all rails unless masked
// - input overvoltage holds the inrush gate off until it clears
// - input overcurrent warning raises interrupt unless masked
// - interrupt pin is open drain, only ever pulls low
// - external supply enable follows sequencer with on and off delays
// - external power good can trigger internal rails in sequence
// - factory image picks reset monitored rails and trigger sources
`ifndef FAULT_SUP_MAP_SVH
`define FAULT_SUP_MAP_SVH
// status byte addresses, group h first, group a last
`define ST_OFFS {8'he5, 8'ha6, 8'ha0, 8'h05, 8'h04, 8'h03, 8'h01, 8'h00}
`define FLAG_BASE 8'h20
`define MASK_BASE 8'h40
`define RDLY_ADDR 8'h60
`define MASK_RST 8'hff
`define RDLY_RST 2'h0
// bit positions inside groups e and g
`define TWARN_BIT 0
`define TSHDN_BIT 1
`define INOCW_BIT 0
// factory image fields
`define IMG_MON_LSB 0
`define IMG_TRIG_LSB 5
`define IMG_ON_LSB 10
`define IMG_OFF_LSB 13
`define IMG_RST 16'h001f
// timing
`define CLK_NS 5
`define MS_NS 1_000_000
`define LDO_ILIM_NS 16_000
`define BUCK_OC_CYC 5'h10
`define HOLDOFF_MS 7'h64
`define RESTART_MS 4'he
`define RDLY_MS_0 7'h14
`define RDLY_MS_1 7'h28
`define RDLY_MS_2 7'h3c
`define RDLY_MS_3 7'h64
`endif

// *** logic/fault_sup_pkg.sv ***
// types shared by the fault supervisor
// assumes nothing beyond a SystemVerilog compiler
`default_nettype none
package fault_sup_pkg;
   // power path sequencer states
   typedef enum logic [1:0] {
      SEQ_OFF,
      SEQ_RUN,
      SEQ_HOLD
   } seq_state_t;
endpackage
`default_nettype wire

// *** sim/host_model.sv ***
// host side of the register port: byte reads and writes
// assumes the bench calls its tasks from the falling edge of clk_i
`timescale 1ns/100ps
`default_nettype none
module host_model (
   // clock
   input wire logic clk_i,
   // register port
   output logic rd_o,
   output logic wr_o,
   output logic [7:0] addr_o,
   output logic [7:0] wdata_o,
   input wire logic [7:0] rdata_i
);
   // idle values are inverted so a stale address is never reused
   initial begin
      rd_o = 1'b0;
      wr_o = 1'b0;
      addr_o = 8'hff;
      wdata_o = 8'hff;
   end
   // one strobe cycle, taken at the single rising edge inside it
   task automatic wr(input logic [7:0] a, input logic [7:0] v);
      @(negedge clk_i);
      wr_o = 1'b1;
      addr_o = a;
      wdata_o = v;
      @(negedge clk_i);
      wr_o = 1'b0;
      addr_o = ~a;
      wdata_o = ~v;
   endtask
   // a status read also clears what is no longer live
   task automatic rd(input logic [7:0] a, output logic [7:0] v);
      @(negedge clk_i);
      rd_o = 1'b1;
      addr_o = a;
      @(negedge clk_i);
      rd_o = 1'b0;
      addr_o = ~a;
      @(negedge clk_i);
      v = rdata_i;
   endtask
endmodule
`default_nettype wire

// *** sim/pmic_fault_irq_reset_supervisor_bench.sv ***
// bench for the fault supervisor with a host model on the register port
// assumes ideal rails: power good follows each enable at once
`timescale 1ns/100ps
`include "fault_sup_map.svh"
`default_nettype none
module pmic_fault_irq_reset_supervisor_bench;
   // ****************************************
   // signals and the design
   // ****************************************
   localparam int MS = 20;
   logic mclk_i = 1'b0, rstn_i = 1'b0, rd, wr;
   logic [7:0] addr, wdata, rdata, d;
   logic [2:0] b_ov = 3'h0, b_uv = 3'h0, b_oc75 = 3'h0, b_oc122 = 3'h0;
   logic [2:0] b_sw = 3'h0;
   logic [1:0] l_ilim = 2'h0, l_ss = 2'h0;
   logic t_warn = 1'b0, t_shdn = 1'b0, i_ov = 1'b0, i_uv = 1'b0;
   logic i_ocw = 1'b0, external_supply_enable, gate, srst_n, irq_d, irq_oe_n;
   logic [4:0] rail_en;
   logic [63:0] offs = `ST_OFFS;
   logic [15:0] obs;
   logic [15:0] exp_q[$];
   event obs_ev;
   int error_cnt = 0, checked = 0, cycles = 0, n, seed = 32'hc612;
   host_model h (.clk_i(mclk_i), .rd_o(rd), .wr_o(wr), .addr_o(addr),
      .wdata_o(wdata), .rdata_i(rdata));
   pmic_fault_irq_reset_supervisor #(.MS_CYCLES(MS), .LDO_CYCLES(8)) i_dut (
      .mclk_i(mclk_i), .rstn_i(rstn_i), .reg_rd_i(rd), .reg_wr_i(wr),
      .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_rdata_o(rdata),
      .buck_ov_i(b_ov), .buck_uv_i(b_uv), .buck_oc75_i(b_oc75),
      .buck_oc122_i(b_oc122), .buck_sw_clk_i(b_sw), .ldo_ov_i(2'h0),
      .ldo_uv_i(2'h0), .ldo_ilim_i(l_ilim), .ldo_ss_done_i(l_ss),
      .temp_warn_i(t_warn), .temp_shdn_i(t_shdn), .in_ov_i(i_ov),
      .in_uv_i(i_uv), .in_ocw_i(i_ocw), .rail_pg_i(rail_en),
      .external_power_good_i(external_supply_enable), .rail_en_o(rail_en),
      .inrush_gate_drive_o(gate), .external_supply_enable_o(external_supply_enable),
      .sys_reset_n_o(srst_n), .fault_irq_n_i(irq_oe_n | irq_d),
      .fault_irq_n_o(irq_d), .fault_irq_n_oe_n_o(irq_oe_n));
   // 200 MHz core clock
   initial begin
      forever #2.5 mclk_i = ~mclk_i;
   end
   // ****************************************
   // scoreboard, watchdog and verdict
   // ****************************************
   task automatic chk(input logic [15:0] e, input logic [15:0] g);
      exp_q.push_back(e);
      obs = g;
      ->obs_ev;
      #1;
   endtask
   // out of range reports the measured count itself
   task automatic rng(input int lo, input int hi);
      chk(lo[15:0], (n >= lo && n <= hi) ? lo[15:0] : n[15:0]);
   endtask
   always @(obs_ev) begin
      checked++;
      if (obs !== exp_q[0]) begin
         error_cnt++;
         $display("wrong value at %0t: expected %h got %h", $time,
            exp_q[0], obs);
      end
      void'(exp_q.pop_front());
   end
   task automatic stop_test();
      $display("checks %0d errors %0d", checked, error_cnt);
      if (error_cnt == 0 && checked > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   // a hang counts as one mismatch
   always @(posedge mclk_i) begin
      cycles++;
      if (cycles == 40000) begin
         error_cnt++;
         stop_test();
      end
   end
   // ****************************************
   // helpers
   // ****************************************
   function automatic logic probe(input int w);
      if (w < 5) return rail_en[w];
      if (w == 5) return srst_n;
      return irq_oe_n;
   endfunction
   // bounded wait at falling edges, count left in n
   task automatic wait_on(input int w, input logic v, input int lim);
      n = 0;
      while (probe(w) !== v && n < lim) begin
         @(negedge mclk_i);
         n++;
      end
   endtask
   task automatic pause(input int c);
      repeat (c) @(negedge mclk_i);
   endtask
   task automatic set_src(input int k, input logic v);
      if (k == 0) t_warn = v;
      if (k == 1) i_ocw = v;
      if (k == 2) i_ov = v;
   endtask
   // ****************************************
   // main sequence
   // ****************************************
   logic [7:0] mask_a[3] = '{8'h44, 8'h46, 8'h45};
   logic [7:0] st_a[3] = '{8'h05, 8'ha6, 8'ha0};
   initial begin
      l_ss = 2'h1;
      pause(10);
      rstn_i = 1'b1;
      chk(1'b0, srst_n);
      wait_on(5, 1'b1, 30 * MS);
      rng(19 * MS, 21 * MS);
      chk(2'h3, {external_supply_enable, gate});
      for (int i = 0; i < 8; i++) begin
         h.rd(offs[8*i+:8], d);
         chk(8'h00, d);
         h.rd(8'h40 + i[7:0], d);
         chk(`MASK_RST, d);
         n = $random(seed);
         h.wr(8'h40 + i[7:0], n[7:0]);
         h.rd(8'h40 + i[7:0], d);
         chk(n[7:0], d);
         h.wr(8'h40 + i[7:0], `MASK_RST);
      end
      // masked flag, then unmasked latch, read while live, read after
      for (int k = 0; k < 3; k++) begin
         set_src(k, 1'b1);
         pause(8);
         h.rd(mask_a[k] - 8'h20, d);
         chk(8'h01, d);
         chk(1'b1, irq_oe_n);
         set_src(k, 1'b0);
         pause(8);
         h.wr(mask_a[k], 8'hfe);
         set_src(k, 1'b1);
         wait_on(6, 1'b0, 10);
         chk(1'b0, irq_oe_n);
         chk(1'b0, irq_d);
         h.rd(st_a[k], d);
         chk(8'h01, d);
         pause(4);
         chk(1'b0, irq_oe_n);
         if (k == 2) chk(2'h0, {gate, srst_n});
         set_src(k, 1'b0);
         pause(8);
         chk(1'b0, irq_oe_n);
         h.rd(st_a[k], d);
         chk(8'h01, d);
         pause(4);
         chk(1'b1, irq_oe_n);
         h.rd(st_a[k], d);
         chk(8'h00, d);
         h.wr(mask_a[k], `MASK_RST);
      end
      wait_on(5, 1'b1, 30 * MS);
      chk(1'b1, srst_n);
      h.wr(`RDLY_ADDR, 8'h01);
      h.rd(`RDLY_ADDR, d);
      chk(8'h01, d);
      i_uv = 1'b1;
      wait_on(5, 1'b0, 8);
      chk(1'b0, srst_n);
      i_uv = 1'b0;
      wait_on(5, 1'b1, 50 * MS);
      rng(39 * MS, 42 * MS);
      // single buck trip, masks all set
      b_oc122 = 3'h1;
      wait_on(0, 1'b0, 8);
      chk(5'h1e, rail_en);
      b_oc122 = 3'h0;
      wait_on(0, 1'b1, 20 * MS);
      rng(13 * MS - 10, 15 * MS);
      // unmasked buck over and undervoltage: all off, reset low, holdoff
      wait_on(5, 1'b1, 50 * MS);
      chk(1'b1, srst_n);
      h.wr(8'h40, 8'h00);
      {b_ov, b_uv} = 6'h0a;
      wait_on(5, 1'b0, 8);
      chk(1'b0, srst_n);
      pause(6);
      chk(5'h00, rail_en);
      h.rd(8'h00, d);
      chk(8'h11, d);
      {b_ov, b_uv} = 6'h00;
      wait_on(0, 1'b1, 110 * MS);
      rng(98 * MS, 102 * MS);
      h.rd(8'h00, d);
      chk(8'h11, d);
      h.wr(8'h40, `MASK_RST);
      // buck current at 75 percent: 16 switch edges, then 18
      b_oc75 = 3'h4;
      for (int i = 0; i < 18; i++) begin
         if (i == 16) begin
            h.rd(8'h22, d);
            chk(8'h00, d);
         end
         b_sw = 3'h4;
         pause(4);
         b_sw = 3'h0;
         pause(4);
      end
      h.rd(8'h22, d);
      chk(8'h04, d);
      b_oc75 = 3'h0;
      // ldo limit counts only after soft start
      l_ilim = 2'h2;
      pause(30);
      h.rd(8'h23, d);
      chk(8'h00, d);
      l_ss = 2'h3;
      pause(30);
      h.rd(8'h23, d);
      chk(8'h02, d);
      l_ilim = 2'h0;
      // thermal shutdown, masked then unmasked
      t_shdn = 1'b1;
      pause(20);
      chk(5'h1f, rail_en);
      h.wr(8'h44, 8'hfd);
      wait_on(0, 1'b0, 10);
      chk(5'h00, rail_en);
      t_shdn = 1'b0;
      stop_test();
   end
endmodule
`default_nettype wire
